// *** eeprom_link_pkg.sv ***
// shared constants and types for the serial eeprom command port
package eeprom_link_pkg;
	// clock and timing
	localparam int CLK_FREQ_HZ  = 100_000_000;
	localparam int PROG_TIME_MS = 6;
	localparam int PROG_CYC     = PROG_TIME_MS * (CLK_FREQ_HZ / 1000);
	localparam int PROG_W       = 20;
	localparam int CSL_TIME_NS  = 250;
	localparam int CSL_CYC      = (CSL_TIME_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;
	localparam int CSL_W        = 5;
	// array shape
	localparam int WORDS        = 256;
	localparam int WORD_W       = 16;
	localparam int SH_W         = 26;
	localparam logic [15:0] ERASED_WORD = 16'hffff;
	// frame field lengths, counted in bits after the start bit
	localparam logic [4:0] OPC_LEN  = 5'h02;
	localparam logic [4:0] AW_WIDE  = 5'h08;
	localparam logic [4:0] AW_NARW  = 5'h09;
	localparam logic [4:0] DW_WIDE  = 5'h10;
	localparam logic [4:0] DW_NARW  = 5'h08;
	// opcodes and extended sub-codes
	localparam logic [1:0] OP_EXT   = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_READ  = 2'h2;
	localparam logic [1:0] OP_ERASE = 2'h3;
	localparam logic [1:0] SUB_PROG_DISABLE = 2'h0;
	localparam logic [1:0] SUB_FILL_ALL     = 2'h1;
	localparam logic [1:0] SUB_ERASE_ALL    = 2'h2;
	localparam logic [1:0] SUB_PROG_ENABLE  = 2'h3;
	// apb register map
	localparam int AW_APB = 12;
	localparam logic [11:0] CTRL_OFS   = 12'h000;
	localparam logic [11:0] STATUS_OFS = 12'h004;
	localparam logic        CTRL_RST   = 1'h0;
	localparam int CTRL_HV_BIT   = 0;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_WEN_BIT  = 1;
	localparam int STAT_SHOW_BIT = 2;
	localparam int STAT_PEND_BIT = 3;
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_CMD  = 5'b00010,
		ST_DATA = 5'b00100,
		ST_READ = 5'b01000,
		ST_DONE = 5'b10000
	} frame_state_e;
	typedef enum logic [1:0] {
		ACT_ERASE     = 2'h0,
		ACT_WRITE     = 2'h1,
		ACT_ERASE_ALL = 2'h2,
		ACT_FILL      = 2'h3
	} act_e;
endpackage

// *** eeprom_link.sv ***
// serial eeprom command port with apb status and control
//
// Function
// RULE_01 - x16 frame: 27 or 11 clocks
// RULE_02 - x8 frame: 20 or 12 clocks
// RULE_03 - opcode and extended sub-code decoding
// RULE_04 - width select high means x16
// RULE_05 - input bits sampled on clock rise
// RULE_06 - output floats unless data or status
// RULE_07 - status low busy, high ready
// RULE_08 - start on first rise with select, input high
// RULE_09 - nothing happens before a start bit
// RULE_10 - execute only after full frame
// RULE_11 - host keeps clock or input low raising select
// RULE_12 - power-up write-disabled, programming ignored
// RULE_13 - enable persists until disable executes
// RULE_14 - reads ignore the enable latch
// RULE_15 - erase sets word ones, starts select fall
// RULE_16 - fast variant starts on clock edge
// RULE_17 - select low 250 ns then status shown
// RULE_18 - start bit plus select fall clears status
// RULE_19 - erase-all sets entire array to ones
// RULE_20 - read: zero bit then word, msb first
// RULE_21 - select high continues sequential read
// RULE_22 - write stores word, start per variant
// RULE_23 - select low resets decoding
// RULE_24 - started programming completes regardless
// RULE_25 - programming cycle uses counter, 6 ms
// RULE_26 - no new instruction while busy
//
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
module eeprom_link #(
	parameter int PROG_CYCLES = eeprom_link_pkg::PROG_CYC
) (
	input  wire logic                              pclk,
	input  wire logic                              presetn,
	input  wire logic [eeprom_link_pkg::AW_APB-1:0] paddr,
	input  wire logic                              psel,
	input  wire logic                              penable,
	input  wire logic                              pwrite,
	input  wire logic [31:0]                       pwdata,
	output logic      [31:0]                       prdata,
	output logic                                   pready,
	output logic                                   pslverr,
	input  wire logic                              chip_select,
	input  wire logic                              serial_clock,
	input  wire logic                              serial_in,
	input  wire logic                              word_width_select,
	output logic                                   serial_out,
	output logic                                   serial_out_oe
);
	import eeprom_link_pkg::*;

	logic               cs_m, cs_s, cs_d;
	logic               ck_m, ck_s, ck_d;
	logic               di_m, di_s;
	logic               org_m, org_s;
	logic               sclk_rise, cs_fall, cs_rise;
	frame_state_e       state_r;
	logic [4:0]         cnt_r, cnt_nxt;
	logic [SH_W-1:0]    sh_r, sh_nxt;
	logic [4:0]         aw, dw, cmd_end, data_end;
	logic [1:0]         dec_op, dec_sub;
	logic [8:0]         dec_addr, addr_r, tgt_addr_r;
	logic [15:0]        dec_data, tgt_data_r;
	logic               cmd_done, data_done, start_seen;
	logic               fill_r, wen_r, prog_req;
	act_e               req_act, act_r;
	logic               pend_r, busy_r, prog_flag_r, clr_arm_r;
	logic [PROG_W-1:0]  prog_left_r;
	logic               tgt_wide_r, start_now, commit;
	logic [WORD_W-1:0]  mem_r [WORDS];
	logic [7:0]         word_idx;
	logic [15:0]        wr_val, rd_sh_r, rd_nxt_word;
	logic               rd_on_r, rd_bit_r;
	logic [4:0]         rd_left_r;
	logic [8:0]         rd_addr_r, rd_next_addr;
	logic [CSL_W-1:0]   csl_cnt_r;
	logic               show_r, ctrl_hv_r;
	logic               apb_setup, apb_wr;
	logic               out_r, out_oe_r;
	logic               pready_r, pslverr_r;
	logic [31:0]        prdata_r;

	// every serial link pin passes two flops before any logic looks at it; the apb pins are used directly
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{cs_m, cs_s, cs_d, ck_m, ck_s, ck_d, di_m, di_s, org_m, org_s} <= 10'h000;
		end else begin
			// the third select and clock flops only feed the edge detectors
			{cs_d, cs_s, cs_m} <= {cs_s, cs_m, chip_select};
			{ck_d, ck_s, ck_m} <= {ck_s, ck_m, serial_clock};
			{di_s, di_m}       <= {di_m, serial_in};
			{org_s, org_m}     <= {org_m, word_width_select};
		end
	end

	// edges of the sampled link clock and select
	assign sclk_rise = ck_s & ~ck_d; // RULE_05
	assign cs_fall   = cs_d & ~cs_s;
	assign cs_rise   = cs_s & ~cs_d;

	// frame geometry follows the width select pin
	always_comb begin
		aw       = org_s ? AW_WIDE : AW_NARW; // RULE_04
		dw       = org_s ? DW_WIDE : DW_NARW;
		cmd_end  = OPC_LEN + aw; // RULE_01 RULE_02
		data_end = cmd_end + dw; // RULE_01 RULE_02
	end

	// field extraction from the shift register including this bit
	always_comb begin
		cnt_nxt  = cnt_r + 5'h01;
		sh_nxt   = {sh_r[SH_W-2:0], di_s};
		dec_op   = 2'(sh_nxt >> aw); // RULE_03
		dec_sub  = 2'(sh_nxt >> (aw - 5'h02)); // RULE_03
		dec_addr = 9'(sh_nxt) & (org_s ? 9'h0ff : 9'h1ff);
		dec_data = 16'(sh_nxt) & (org_s ? 16'hffff : 16'h00ff);
	end

	// frame milestones, only on sampled clock rises with select high
	assign start_seen = cs_s & sclk_rise & (state_r == ST_IDLE) & di_s; // RULE_08
	assign cmd_done   = cs_s & sclk_rise & (state_r == ST_CMD) & (cnt_nxt == cmd_end); // RULE_10
	assign data_done  = cs_s & sclk_rise & (state_r == ST_DATA) & (cnt_nxt == data_end); // RULE_10

	// frame sequencer; select low wipes any partial frame
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= ST_IDLE;
			cnt_r   <= 5'h00;
			sh_r    <= '0;
		end else if (!cs_s) begin
			state_r <= ST_IDLE; // RULE_23
			cnt_r   <= 5'h00;
		end else if (sclk_rise) begin
			unique case (state_r)
				ST_IDLE: begin
					// a start bit is ignored while the array is busy
					if (di_s && !busy_r) begin // RULE_09 RULE_26
						state_r <= ST_CMD;
						cnt_r   <= 5'h00;
					end
				end
				ST_CMD: begin
					sh_r  <= sh_nxt;
					cnt_r <= cnt_nxt;
					if (cnt_nxt == cmd_end) begin
						if (dec_op == OP_READ)
							state_r <= ST_READ;
						else if (dec_op == OP_WRITE || (dec_op == OP_EXT && dec_sub == SUB_FILL_ALL))
							state_r <= ST_DATA;
						else
							state_r <= ST_DONE;
					end
				end
				ST_DATA: begin
					sh_r  <= sh_nxt;
					cnt_r <= cnt_nxt;
					if (cnt_nxt == data_end)
						state_r <= ST_DONE;
				end
				ST_READ, ST_DONE: state_r <= state_r; // RULE_21
			endcase
		end
	end

	// address and kind of data command, held for the data phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_r <= 9'h000;
			fill_r <= 1'b0;
		end else if (cmd_done) begin
			addr_r <= dec_addr;
			fill_r <= (dec_op == OP_EXT);
		end
	end

	// enable latch: cleared only by reset or the disable command
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wen_r <= 1'b0; // RULE_12
		end else if (cmd_done && dec_op == OP_EXT) begin
			if (dec_sub == SUB_PROG_ENABLE)
				wen_r <= 1'b1; // RULE_13
			else if (dec_sub == SUB_PROG_DISABLE)
				wen_r <= 1'b0; // RULE_13
		end
	end

	// programming requests need a complete frame and the latch set
	always_comb begin
		prog_req = 1'b0;
		req_act  = ACT_ERASE;
		if (cmd_done && dec_op == OP_ERASE) begin
			prog_req = wen_r; // RULE_12 RULE_15
		end else if (cmd_done && dec_op == OP_EXT && dec_sub == SUB_ERASE_ALL) begin
			prog_req = wen_r; // RULE_12 RULE_19
			req_act  = ACT_ERASE_ALL;
		end else if (data_done) begin
			prog_req = wen_r; // RULE_12 RULE_22
			req_act  = fill_r ? ACT_FILL : ACT_WRITE;
		end
	end

	// fast variant launches at the frame end, others at select fall
	assign start_now = (prog_req & ctrl_hv_r) | (pend_r & cs_fall); // RULE_15 RULE_16 RULE_22
	assign commit    = busy_r & (prog_left_r == '0);

	// self-timed cycle; it does not look at select once started
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend_r      <= 1'b0;
			busy_r      <= 1'b0;
			prog_left_r <= '0;
			act_r       <= ACT_ERASE;
			tgt_addr_r  <= 9'h000;
			tgt_data_r  <= 16'h0000;
			tgt_wide_r  <= 1'b0;
		end else begin
			if (prog_req) begin
				act_r      <= req_act;
				tgt_addr_r <= data_done ? addr_r : dec_addr;
				tgt_data_r <= (req_act == ACT_ERASE) ? ERASED_WORD : dec_data; // RULE_15
				tgt_wide_r <= org_s;
				pend_r     <= ~ctrl_hv_r;
			end else if (cs_fall) begin
				pend_r <= 1'b0;
			end
			if (start_now) begin
				busy_r      <= 1'b1;
				prog_left_r <= PROG_W'(PROG_CYCLES - 1); // RULE_25
			end else if (commit) begin
				busy_r <= 1'b0; // RULE_24
			end else if (busy_r) begin
				prog_left_r <= prog_left_r - 1'b1;
			end
		end
	end

	// ready indication stays armed until start bit then select fall
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prog_flag_r <= 1'b0;
			clr_arm_r   <= 1'b0;
		end else begin
			if (start_now)
				prog_flag_r <= 1'b1;
			else if (cs_fall && clr_arm_r)
				prog_flag_r <= 1'b0; // RULE_18
			if (start_now || cs_fall)
				clr_arm_r <= 1'b0;
			else if (start_seen && prog_flag_r && !busy_r)
				clr_arm_r <= 1'b1; // RULE_18
		end
	end

	// value written at commit; x8 writes merge into the word
	always_comb begin
		word_idx = tgt_wide_r ? tgt_addr_r[7:0] : tgt_addr_r[8:1];
		wr_val   = mem_r[word_idx];
		unique case (act_r)
			ACT_ERASE_ALL: wr_val = ERASED_WORD; // RULE_19
			ACT_FILL: wr_val = tgt_wide_r ? tgt_data_r : {tgt_data_r[7:0], tgt_data_r[7:0]};
			// single erase writes ones, so an x8 erase keeps the other byte
			ACT_ERASE, ACT_WRITE: begin
				if (tgt_wide_r)
					wr_val = tgt_data_r; // RULE_15 RULE_22
				else if (tgt_addr_r[0])
					wr_val = {mem_r[word_idx][15:8], tgt_data_r[7:0]};
				else
					wr_val = {tgt_data_r[7:0], mem_r[word_idx][7:0]};
			end
		endcase
	end

	// array storage; no reset, contents survive like the real cells
	for (genvar gi = 0; gi < WORDS; gi++) begin : g_word
		always_ff @(posedge pclk) begin
			if (commit && (act_r == ACT_ERASE_ALL || act_r == ACT_FILL || word_idx == 8'(gi)))
				mem_r[gi] <= wr_val; // RULE_19
		end
	end

	// fetch a word left-aligned; x8 even addresses take the high byte
	function automatic logic [15:0] fetch(input logic [8:0] a, input logic wide);
		logic [15:0] w;
		w = wide ? mem_r[a[7:0]] : mem_r[a[8:1]];
		if (wide)
			return w;
		return a[0] ? {w[7:0], 8'h00} : {w[15:8], 8'h00};
	endfunction

	assign rd_next_addr = (rd_addr_r + 9'h001) & (org_s ? 9'h0ff : 9'h1ff);
	always_comb rd_nxt_word = fetch(rd_next_addr, org_s); // process form so array updates are seen

	// read shifter: dummy zero, word msb first, then next words
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_on_r   <= 1'b0;
			rd_bit_r  <= 1'b0;
			rd_sh_r   <= 16'h0000;
			rd_left_r <= 5'h00;
			rd_addr_r <= 9'h000;
		end else if (!cs_s) begin
			rd_on_r <= 1'b0;
		end else if (cmd_done && dec_op == OP_READ) begin
			rd_on_r   <= 1'b1; // RULE_14
			rd_bit_r  <= 1'b0; // RULE_20
			rd_sh_r   <= fetch(dec_addr, org_s);
			rd_left_r <= dw;
			rd_addr_r <= dec_addr;
		end else if (rd_on_r && sclk_rise) begin
			if (rd_left_r != 5'h00) begin
				rd_bit_r  <= rd_sh_r[15]; // RULE_20
				rd_sh_r   <= {rd_sh_r[14:0], 1'b0};
				rd_left_r <= rd_left_r - 5'h01;
			end else begin
				// no dummy bit between sequential words
				rd_bit_r  <= rd_nxt_word[15]; // RULE_21
				rd_sh_r   <= {rd_nxt_word[14:0], 1'b0};
				rd_left_r <= dw - 5'h01;
				rd_addr_r <= rd_next_addr;
			end
		end
	end

	// select low time, saturating so long waits cannot wrap
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			csl_cnt_r <= '0;
		else if (cs_s)
			csl_cnt_r <= '0;
		else if (csl_cnt_r != CSL_W'(CSL_CYC))
			csl_cnt_r <= csl_cnt_r + 1'b1;
	end

	// status shown after a long enough select low once programming ran
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			show_r <= 1'b0;
		else if (cs_fall)
			show_r <= 1'b0; // RULE_06
		else if (cs_rise && prog_flag_r && csl_cnt_r == CSL_W'(CSL_CYC))
			show_r <= 1'b1; // RULE_17
	end

	// pin driver; read data takes precedence over status
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_r    <= 1'b0;
			out_oe_r <= 1'b0;
		end else begin
			out_oe_r <= cs_s & (rd_on_r | show_r); // RULE_06
			out_r    <= rd_on_r ? rd_bit_r : ~busy_r; // RULE_07
		end
	end

	assign serial_out    = out_r;
	assign serial_out_oe = out_oe_r;
	// apb: answer in the first access cycle
	assign apb_setup = psel & ~penable;
	assign apb_wr    = psel & penable & pready_r & pwrite;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0000_0000;
		end else if (apb_setup) begin
			pready_r  <= 1'b1;
			pslverr_r <= (paddr != CTRL_OFS) && (paddr != STATUS_OFS);
			prdata_r  <= 32'h0000_0000;
			if (!pwrite && paddr == CTRL_OFS)
				prdata_r[CTRL_HV_BIT] <= ctrl_hv_r;
			else if (!pwrite && paddr == STATUS_OFS) begin
				prdata_r[STAT_BUSY_BIT] <= busy_r;
				prdata_r[STAT_WEN_BIT]  <= wen_r;
				prdata_r[STAT_SHOW_BIT] <= show_r;
				prdata_r[STAT_PEND_BIT] <= pend_r;
			end
		end else begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end
	end

	// control register; status register is read-only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ctrl_hv_r <= CTRL_RST;
		else if (apb_wr && paddr == CTRL_OFS)
			ctrl_hv_r <= pwdata[CTRL_HV_BIT];
	end

	assign pready  = pready_r;
	assign pslverr = pslverr_r;
	assign prdata  = prdata_r;
endmodule // eeprom_link

// *** eeprom_link_monitor.sv ***
// assertions on the apb side and the pin enable of the eeprom command port
`timescale 1ns/10ps
module eeprom_link_monitor #(
	parameter int PROG_CYCLES = 200
) (
	input wire logic                               pclk,
	input wire logic                               presetn,
	input wire logic [eeprom_link_pkg::AW_APB-1:0] paddr,
	input wire logic                               psel,
	input wire logic                               penable,
	input wire logic                               pwrite,
	input wire logic [31:0]                        pwdata,
	input wire logic [31:0]                        prdata,
	input wire logic                               pready,
	input wire logic                               pslverr,
	input wire logic                               chip_select,
	input wire logic                               serial_out_oe
);
	import eeprom_link_pkg::*;
	logic ctrl_m;
	// control bit mirror; it moves only at a completed write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ctrl_m <= CTRL_RST;
		else if (psel && penable && pready && pwrite && paddr == CTRL_OFS)
			ctrl_m <= pwdata[CTRL_HV_BIT];
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence done_s;
		psel && penable && pready;
	endsequence
	apb_ready_a: assert property (setup_s |=> done_s) else $error("apb access not answered at once");
	ready_pulse_a: assert property (pready |=> !pready) else $error("pready held too long");
	err_map_a: assert property (done_s ##0 (paddr != CTRL_OFS && paddr != STATUS_OFS) |-> pslverr)
		else $error("unmapped access without error");
	err_ok_a: assert property (done_s ##0 (paddr == CTRL_OFS || paddr == STATUS_OFS) |-> !pslverr)
		else $error("mapped access flagged");
	wr_zero_a: assert property (done_s ##0 pwrite |-> prdata == 32'h0) else $error("read data on write");
	ctrl_read_a: assert property (done_s ##0 (!pwrite && paddr == CTRL_OFS) |-> prdata == {31'h0, ctrl_m})
		else $error("control readback wrong");
	float_desel_a: assert property (!chip_select [*8] |-> !serial_out_oe)
		else $error("pin driven while deselected");
	oe_sel_a: assert property ($rose(serial_out_oe) |-> $past(chip_select, 3))
		else $error("pin driven without select");
endmodule // eeprom_link_monitor

bind eeprom_link eeprom_link_monitor #(.PROG_CYCLES(PROG_CYCLES)) mon_u (
	.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .chip_select(chip_select),
	.serial_out_oe(serial_out_oe));

// *** serial_host.sv ***
// behavioural host driving the serial link of the eeprom command port
`timescale 1ns/10ps
module serial_host (
	input  wire logic pclk,
	output logic      chip_select,
	output logic      serial_clock,
	output logic      serial_in,
	input  wire logic serial_out,
	input  wire logic serial_out_oe
);
	// link idle: clock stands still low between frames
	initial begin
		chip_select = 1'b0;
		serial_clock = 1'b0;
		serial_in = 1'b0;
	end
	task automatic sel();
		@(posedge pclk);
		chip_select <= 1'b1;
	endtask
	// one 80 ns period; pin looked at just before the rise, z when floating
	task automatic clk_bit(input logic b, output logic q);
		serial_in <= b;
		repeat (4) @(posedge pclk);
		q = serial_out_oe ? serial_out : 1'bz;
		serial_clock <= 1'b1;
		repeat (4) @(posedge pclk);
		serial_clock <= 1'b0;
	endtask
	// msb first, start bit included; caller gives the length per width
	task automatic frame(input logic [31:0] f, input int n);
		logic q;
		sel();
		for (int i = n - 1; i >= 0; i--)
			clk_bit(f[i], q);
	endtask
	// input bits are junk here, so the device must ignore them
	task automatic shift(input int n, output logic [63:0] got);
		logic q;
		got = 64'h0;
		for (int i = 0; i < n; i++) begin
			clk_bit(1'($urandom), q);
			got = {got[62:0], q};
		end
	endtask
	// long enough low time for status polling
	task automatic desel();
		chip_select <= 1'b0;
		repeat (30) @(posedge pclk);
	endtask
endmodule // serial_host

// *** tb_top.sv ***
// self-checking bench for the serial eeprom command port
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; \
	$display("ERROR %0t: got %h expected %h", $time, g, e); end end
module tb_top;
	import eeprom_link_pkg::*;
	localparam int PROG_N = 200;
	logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic              chip_select, serial_clock, serial_in, word_width_select, serial_out, serial_out_oe;
	logic [AW_APB-1:0] paddr;
	logic [31:0]       pwdata, prdata, q;
	logic [63:0]       res_v, exp_v, got;
	logic [63:0]       exp_q[$];
	logic [15:0]       d1, d2, d3;
	logic [7:0]        d4;
	int                error_cnt, checked, cyc;
	event              res_e;
	eeprom_link #(.PROG_CYCLES(PROG_N)) dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .chip_select(chip_select), .serial_clock(serial_clock), .serial_in(serial_in),
		.word_width_select(word_width_select), .serial_out(serial_out), .serial_out_oe(serial_out_oe));
	serial_host host_u (.pclk(pclk), .chip_select(chip_select), .serial_clock(serial_clock),
		.serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe));
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// watcher: each result against the oldest note
	always @(res_e) begin
		exp_v = exp_q.pop_front();
		`CHK(res_v, exp_v)
	end
	// hang guard, several times the expected run
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 40000) begin
			error_cnt++;
			finish_test();
		end
	end
	task automatic finish_test();
		$display("checked %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic apb_xfer(input logic [AW_APB-1:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic apb_chk(input logic [AW_APB-1:0] a, input logic [63:0] e);
		exp_q.push_back(e);
		apb_xfer(a, 1'b0, 32'h0, q);
		res_v = 64'(q);
		-> res_e;
	endtask
	task automatic rd_chk(input logic [31:0] f, input int n, input int m, input logic [63:0] e);
		exp_q.push_back(e);
		host_u.frame(f, n);
		host_u.shift(m, got);
		host_u.desel();
		res_v = got;
		-> res_e;
	endtask
	task automatic pin_chk(input logic e);
		exp_q.push_back({63'h0, e});
		repeat (8) @(posedge pclk);
		res_v = {63'h0, serial_out_oe ? serial_out : 1'bz};
		-> res_e;
	endtask
	// status poll through a whole cycle, then clear the indication
	task automatic poll();
		host_u.desel();
		host_u.sel();
		pin_chk(1'b0);
		do apb_xfer(STATUS_OFS, 1'b0, 32'h0, q); while (q[STAT_BUSY_BIT] !== 1'b0);
		pin_chk(1'b1);
		host_u.frame(32'h1, 1);
		host_u.desel();
		host_u.sel();
		pin_chk(1'bz);
		host_u.desel();
	endtask
	task automatic prog(input logic [31:0] f, input int n);
		host_u.frame(f, n);
		poll();
	endtask
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		word_width_select = 1'b1;
		void'($urandom(66));
		d1 = 16'($urandom);
		d2 = 16'($urandom);
		d3 = 16'($urandom);
		d4 = 8'($urandom);
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		apb_chk(STATUS_OFS, 64'h0);
		apb_chk(CTRL_OFS, 64'h0);
		apb_xfer(STATUS_OFS, 1'b1, 32'hffffffff, q);
		apb_chk(STATUS_OFS, 64'h0);
		apb_chk(12'h008, 64'h0);
		host_u.frame(32'({1'b1, OP_EXT, SUB_PROG_ENABLE, 6'h0}), 11);
		host_u.desel();
		apb_chk(STATUS_OFS, 64'h2);
		prog(32'({1'b1, OP_ERASE, 8'h05}), 11);
		host_u.frame(32'({1'b1, OP_EXT, SUB_PROG_DISABLE, 6'h0}), 11);
		host_u.desel();
		host_u.frame(32'({1'b1, OP_WRITE, 8'h05, 16'h1234}), 27);
		host_u.desel();
		apb_chk(STATUS_OFS, 64'h0);
		rd_chk(32'({1'b1, OP_READ, 8'h05}), 11, 17, 64'({1'b0, ERASED_WORD}));
		host_u.frame(32'({1'b1, OP_EXT, SUB_PROG_ENABLE, 6'h0}), 11);
		host_u.desel();
		prog(32'({1'b1, OP_WRITE, 8'h05, d1}), 27);
		prog(32'({1'b1, OP_WRITE, 8'h06, d2}), 27);
		host_u.frame(32'({1'b1, OP_WRITE, 8'h08, 16'h5555} >> 1), 26);
		host_u.desel();
		apb_chk(STATUS_OFS, 64'h2);
		apb_xfer(CTRL_OFS, 1'b1, 32'h1, q);
		apb_chk(CTRL_OFS, 64'h1);
		host_u.frame(32'({1'b1, OP_WRITE, 8'h07, d3}), 27);
		apb_chk(STATUS_OFS, 64'h3);
		poll();
		apb_xfer(CTRL_OFS, 1'b1, 32'h0, q);
		rd_chk(32'({1'b1, OP_READ, 8'h05}), 11, 49, 64'({1'b0, d1, d2, d3}));
		word_width_select <= 1'b0;
		repeat (4) @(posedge pclk);
		prog(32'({1'b1, OP_EXT, SUB_FILL_ALL, 7'h0, d4}), 20);
		rd_chk(32'({1'b1, OP_READ, 9'h000}), 12, 9, 64'({1'b0, d4}));
		prog(32'({1'b1, OP_ERASE, 9'h001}), 12);
		prog(32'({1'b1, OP_WRITE, 9'h002, ~d4}), 20);
		rd_chk(32'({1'b1, OP_READ, 9'h000}), 12, 33, 64'({1'b0, d4, 8'hff, ~d4, d4}));
		prog(32'({1'b1, OP_EXT, SUB_ERASE_ALL, 7'h0}), 12);
		rd_chk(32'({1'b1, OP_READ, 9'h003}), 12, 9, 64'({1'b0, 8'hff}));
		word_width_select <= 1'b1;
		repeat (4) @(posedge pclk);
		rd_chk(32'({1'b1, OP_READ, 8'h05}), 11, 17, 64'({1'b0, ERASED_WORD}));
		finish_test();
	end
endmodule // tb_top
